// [rtl/aesb_status_bus.sv]
// Read-side almost-empty status bus: direct word selection or polled walk.
// Assumes all inputs synchronous to sys_clk_in; the bus is shared with
// chained devices, so the output enable shows when this device owns it.
//
// What this block does
// - Strobe at clock edge loads addressed word
// - Polled mode walks words one to four
// - Sync high only with first word
// - Token pulses with last word placed
// - Incoming token starts own word walk
// - Mode pin caught on first edge after reset selects mode
`timescale 1ns/1ps
`default_nettype none

module aesb_status_bus #(
    parameter int NUM_WORDS = aesb_pkg::AESB_NUM_WORDS,
    parameter int WORD_W    = aesb_pkg::AESB_WORD_W,
    parameter int IDX_W     = $clog2(aesb_pkg::AESB_NUM_WORDS)
) (
    input  wire logic                        sys_clk_in,
    input  wire logic                        rst_in,
    input  wire logic                        flag_bus_mode_select_in,
    input  wire logic [NUM_WORDS*WORD_W-1:0] almost_empty_in,
    input  wire logic                        empty_bus_strobe_in,
    input  wire logic [IDX_W-1:0]            read_queue_address_in,
    input  wire logic                        serial_enable_level_in,
    input  wire logic                        chain_head_in,
    input  wire logic                        status_token_in,
    output logic      [WORD_W-1:0]           almost_empty_flag_bus_out,
    output logic                             almost_empty_bus_oe_out,
    output logic                             empty_bus_sync_out,
    output logic                             status_token_out
);

    // Refuse shapes the sequencer cannot serve
    generate
        if (NUM_WORDS < 2 || WORD_W != 8) begin : g_bad_shape
            $error("aesb_status_bus: need two or more 8-bit words");
        end
        if (IDX_W != $clog2(NUM_WORDS)) begin : g_bad_idx
            $error("aesb_status_bus: IDX_W must match NUM_WORDS");
        end
    endgenerate

    // Index constants at the width they meet
    localparam logic [IDX_W-1:0] FIRST_IDX = '0;
    localparam logic [IDX_W-1:0] LAST_IDX  = IDX_W'(NUM_WORDS - 1);
    localparam logic [IDX_W-1:0] IDX_STEP  = IDX_W'(1);

    // Mode capture
    logic                  mode_taken_ff;   // Mode has been sampled
    logic                  polled_ff;       // 1: polled, 0: direct
    // Polled sequencer
    aesb_pkg::aesb_state_e state_ff;        // Walk state
    aesb_pkg::aesb_state_e nxt_state;       // Next walk state
    logic [IDX_W-1:0]      idx_ff;          // Word now on the bus
    logic [IDX_W-1:0]      nxt_idx;         // Word loaded at this edge
    logic                  started_ff;      // Head has kicked the loop
    // Decoded qualifiers
    logic                  prog_done;       // Programming finished
    logic                  poll_go;         // Polled logic may act
    logic                  kick;            // Head device self-start
    logic                  start;           // Begin own walk this edge
    logic                  poll_load;       // A polled word loads now
    logic                  direct_take;     // A direct strobe is taken
    logic [IDX_W-1:0]      sel_idx;         // Word the selector picks
    logic [WORD_W-1:0]     sel_word;        // Picked status word

    // Mode pin is sampled on the first edge after reset release, so the
    // asynchronous reset itself only ever loads constants
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            mode_taken_ff <= 1'h0;
            polled_ff     <= 1'h0;
        end else if (!mode_taken_ff) begin
            mode_taken_ff <= 1'h1;
            polled_ff     <= (flag_bus_mode_select_in ==
                              aesb_pkg::AESB_MODE_POLLED);
        end
    end

    // Strobe and token are ignored while programming is under way
    assign prog_done = (serial_enable_level_in ==
                        aesb_pkg::AESB_PROG_DONE);

    // Polled logic acts only once the mode is known and polled
    assign poll_go = mode_taken_ff && polled_ff && prog_done;

    // Direct strobe counts only in direct mode; in polled mode it is
    // expected low and is ignored anyway
    assign direct_take = mode_taken_ff && !polled_ff && prog_done &&
                         empty_bus_strobe_in;

    // The head of the chain injects the first token once; afterwards the
    // token circulates through the loop wired outside
    assign kick  = chain_head_in && !started_ff;
    assign start = poll_go && (status_token_in || kick);

    // Remember that the head has kicked, so it never injects a second
    // token into a running loop
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            started_ff <= 1'h0;
        end else if (poll_go && kick) begin
            started_ff <= 1'h1;
        end
    end

    // Walk decode: a token starts at word one, then step to the last word;
    // a token arriving with the last word (self loop) restarts at once
    always_comb begin
        nxt_state = state_ff;
        nxt_idx   = idx_ff;
        poll_load = 1'h0;
        case (state_ff)
            aesb_pkg::AESB_ST_IDLE: begin
                if (start) begin
                    nxt_state = aesb_pkg::AESB_ST_RUN;
                    nxt_idx   = FIRST_IDX;
                    poll_load = 1'h1;
                end
            end
            aesb_pkg::AESB_ST_RUN: begin
                if (!poll_go) begin
                    // Programming restarted: drop off the bus
                    nxt_state = aesb_pkg::AESB_ST_IDLE;
                end else if (idx_ff != LAST_IDX) begin
                    nxt_idx   = idx_ff + IDX_STEP;
                    poll_load = 1'h1;
                end else if (start) begin
                    nxt_idx   = FIRST_IDX;
                    poll_load = 1'h1;
                end else begin
                    nxt_state = aesb_pkg::AESB_ST_IDLE;
                end
            end
            default: begin
                nxt_state = aesb_pkg::AESB_ST_IDLE;
            end
        endcase
    end

    // Walk state and word index
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            state_ff <= aesb_pkg::AESB_ST_IDLE;
            idx_ff   <= FIRST_IDX;
        end else begin
            state_ff <= nxt_state;
            idx_ff   <= nxt_idx;
        end
    end

    // One selector serves both modes; modes never overlap
    assign sel_idx = polled_ff ? nxt_idx : read_queue_address_in;

    aesb_word_select #(
        .NUM_WORDS (NUM_WORDS),
        .WORD_W    (WORD_W),
        .IDX_W     (IDX_W)
    ) u_word_select (
        .flags_in  (almost_empty_in),
        .index_in  (sel_idx),
        .word_out  (sel_word)
    );

    // Flag bus: a snapshot of the flags taken at the loading edge; it
    // holds between loads so direct readers see a stable word
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            almost_empty_flag_bus_out <= aesb_pkg::AESB_BUS_RST;
        end else if (direct_take) begin
            almost_empty_flag_bus_out <= sel_word;
        end else if (poll_load) begin
            almost_empty_flag_bus_out <= sel_word;
        end
    end

    // Bus ownership: polled words own it for their cycle only, a direct
    // selection owns it from the first strobe onward
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            almost_empty_bus_oe_out <= 1'h0;
        end else if (polled_ff) begin
            almost_empty_bus_oe_out <= poll_load;
        end else begin
            almost_empty_bus_oe_out <= almost_empty_bus_oe_out ||
                                       direct_take;
        end
    end

    // Sync marks the cycle that holds this device's first word
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            empty_bus_sync_out <= aesb_pkg::AESB_SYNC_RST;
        end else begin
            empty_bus_sync_out <= poll_load &&
                                  (nxt_idx == FIRST_IDX);
        end
    end

    // Token pulses alongside the last word, so the next device in the
    // loop loads its first word on the following edge
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            status_token_out <= aesb_pkg::AESB_TOKEN_RST;
        end else begin
            status_token_out <= poll_load &&
                                (nxt_idx == LAST_IDX);
        end
    end

endmodule // aesb_status_bus

`default_nettype wire

// [shared/aesb_pkg.sv]
// Shared constants of the almost-empty status bus block.
// Assumes one read-port clock domain; no software-visible registers.
package aesb_pkg;

    // Number of status words one device cycles through
    localparam int AESB_NUM_WORDS = 4;
    // Queue flags carried by one status word
    localparam int AESB_WORD_W    = 8;

    // Level of the mode pin that selects polled operation
    localparam logic AESB_MODE_POLLED = 1'h1;
    // Level of the serial enable that marks programming as finished
    localparam logic AESB_PROG_DONE   = 1'h0;

    // Reset values of the outputs
    localparam logic [7:0] AESB_BUS_RST = 8'h00;
    localparam logic       AESB_SYNC_RST  = 1'h0;
    localparam logic       AESB_TOKEN_RST = 1'h0;

    // Sequencer states
    typedef enum logic [0:0] {
        AESB_ST_IDLE = 1'h0,  // Waiting for a token
        AESB_ST_RUN  = 1'h1   // Walking through own status words
    } aesb_state_e;

endpackage

// [rtl/aesb_word_select.sv]
// Splits the flat vector of queue flags into status words and picks one.
// Assumes flags of word k sit at bits [k*WORD_W +: WORD_W].
`timescale 1ns/1ps
`default_nettype none

module aesb_word_select #(
    parameter int NUM_WORDS = aesb_pkg::AESB_NUM_WORDS,
    parameter int WORD_W    = aesb_pkg::AESB_WORD_W,
    parameter int IDX_W     = $clog2(aesb_pkg::AESB_NUM_WORDS)
) (
    input  wire logic [NUM_WORDS*WORD_W-1:0] flags_in,  // One bit per queue
    input  wire logic [IDX_W-1:0]            index_in,  // Word to pick
    output logic      [WORD_W-1:0]           word_out   // Picked word
);

    // Status words laid out as an array
    logic [WORD_W-1:0] words [NUM_WORDS];

    // One slice per status word
    genvar gi;
    generate
        for (gi = 0; gi < NUM_WORDS; gi++) begin : g_word
            assign words[gi] = flags_in[gi*WORD_W +: WORD_W];
        end
    endgenerate

    // Out-of-range index reads as all clear rather than garbage
    always_comb begin
        word_out = '0;
        if (32'(index_in) < NUM_WORDS) begin
            word_out = words[index_in];
        end
    end

endmodule // aesb_word_select

`default_nettype wire

// [bench/aesb_chain_model.sv]
// Chain neighbour model: hands the token back to the device's token input.
// Assumes the token output is a registered one-cycle pulse.
`timescale 1ns/1ps
`default_nettype none
module aesb_chain_model (
    input  wire logic       sys_clk_in,
    input  wire logic       rst_in,
    input  wire logic       loop_en_in,   // Low: chain parked
    input  wire logic [1:0] gap_in,       // Cycles spent in neighbours
    input  wire logic       token_out_in, // Token leaving the device
    output logic            token_back_out
);
    logic [2:0] line_ff;  // Token positions inside slow neighbours
    // A parked chain swallows the token so the walk can end cleanly
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            line_ff <= 3'h0;
        end else begin
            line_ff <= {line_ff[1:0], token_out_in & loop_en_in};
        end
    end
    // Zero gap is one device looped on itself; direct mode gets low
    assign token_back_out = (gap_in == 2'h0) ?
        (token_out_in & loop_en_in) : line_ff[gap_in - 2'h1];
endmodule // aesb_chain_model
`default_nettype wire

// [bench/aesb_status_bus_assertions.sv]
// Port checker of the almost-empty status bus, bound to its top module.
// Assumes default widths: four 8-bit words, 2-bit word address.
`timescale 1ns/1ps
`default_nettype none
module aesb_status_bus_assertions (
    input wire logic        sys_clk_in,
    input wire logic        rst_in,
    input wire logic        flag_bus_mode_select_in,
    input wire logic [31:0] almost_empty_in,
    input wire logic        empty_bus_strobe_in,
    input wire logic [1:0]  read_queue_address_in,
    input wire logic        serial_enable_level_in,
    input wire logic        status_token_in,
    input wire logic [7:0]  almost_empty_flag_bus_out,
    input wire logic        almost_empty_bus_oe_out,
    input wire logic        empty_bus_sync_out,
    input wire logic        status_token_out
);
    logic        seen_ff;  // Mode known from here on
    logic        poll_ff;  // Captured mode pin
    logic [31:0] flag_ff;  // Flags at the last edge
    logic [7:0]  pick;     // Addressed word
    logic        dir;      // Direct mode in force
    logic        pol;      // Polled mode in force
    logic        go;       // Programming finished
    assign pick = almost_empty_in[read_queue_address_in*8 +: 8];
    assign dir = seen_ff && !poll_ff;
    assign pol = seen_ff && poll_ff;
    assign go = !serial_enable_level_in;
    // Mirror the mode capture so the two modes can be told apart
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            seen_ff <= 1'h0;
            poll_ff <= 1'h0;
        end else if (!seen_ff) begin
            seen_ff <= 1'h1;
            poll_ff <= flag_bus_mode_select_in;
        end
    end
    // Snapshot of the flags, as seen by the loading edge
    always_ff @(posedge sys_clk_in) begin
        flag_ff <= almost_empty_in;
    end
    default clocking cb @(posedge sys_clk_in);
    endclocking
    default disable iff (rst_in);
    direct_load_a: assert property (dir && go && empty_bus_strobe_in
        |=> almost_empty_flag_bus_out == $past(pick) && almost_empty_bus_oe_out)
        else $error("direct word not loaded");
    direct_hold_a: assert property (dir && !(go && empty_bus_strobe_in)
        |=> $stable(almost_empty_flag_bus_out)) else $error("bus moved");
    walk_order_a: assert property (empty_bus_sync_out
        |-> almost_empty_flag_bus_out == flag_ff[7:0]
        ##1 almost_empty_flag_bus_out == flag_ff[15:8]
        ##1 almost_empty_flag_bus_out == flag_ff[23:16]
        ##1 almost_empty_flag_bus_out == flag_ff[31:24] && status_token_out)
        else $error("polled word order wrong");
    sync_once_a: assert property (empty_bus_sync_out
        |=> !empty_bus_sync_out [*3]) else $error("sync not single");
    token_after_a: assert property (status_token_out
        |-> $past(empty_bus_sync_out, 3) && almost_empty_bus_oe_out)
        else $error("token not with last word");
    token_pulse_a: assert property (status_token_out
        |=> !status_token_out) else $error("token too long");
    token_start_a: assert property (pol && go && status_token_in
        && (!almost_empty_bus_oe_out || status_token_out)
        |=> empty_bus_sync_out && almost_empty_bus_oe_out)
        else $error("token did not start walk");
    direct_quiet_a: assert property (dir
        |-> !empty_bus_sync_out && !status_token_out)
        else $error("polled output in direct mode");
endmodule // aesb_status_bus_assertions
bind aesb_status_bus aesb_status_bus_assertions aesb_status_bus_assertions_i (.*);
`default_nettype wire

// [bench/aesb_status_bus_tb_top.sv]
// Self-checking bench of the almost-empty status bus, both modes.
// Assumes design defaults; the chain model loops the token back.
`timescale 1ns/1ps
`default_nettype none
`define AESB_CHECK(act_v, exp_v) \
    total_checks++; \
    if ((act_v) !== (exp_v)) begin \
        n_fail++; \
        $display("unexpected at %0t got %h exp %h", $time, act_v, exp_v); \
    end
module aesb_status_bus_tb_top;
    logic        sys_clk = 1'h0;
    logic        rst = 1'h1;
    logic        mode = 1'h0;     // High: polled walk
    logic        head = 1'h0;
    logic [31:0] flags = 32'h0;
    logic        strobe = 1'h0;
    logic [1:0]  addr = 2'h0;
    logic        sen = 1'h0;      // High: programming still running
    logic        loop_en = 1'h0;
    logic [1:0]  gap = 2'h0;
    logic        tok_in;
    logic        tok_out;
    logic        sync;
    logic        oe;
    logic [7:0]  bus;
    logic        taken_q = 1'h0;  // Strobe accepted at coming edge
    logic        taken_d = 1'h0;  // Strobe accepted at last edge
    logic [9:0]  exp_q[$];        // Notes of {word, sync, token}
    logic [9:0]  e_v;
    int          seed = 32'h77a9;
    int          n_fail = 0;
    int          total_checks = 0;
    always #5 sys_clk = ~sys_clk;
    aesb_status_bus aesb_status_bus_i (.sys_clk_in(sys_clk), .rst_in(rst),
        .flag_bus_mode_select_in(mode), .almost_empty_in(flags),
        .empty_bus_strobe_in(strobe), .read_queue_address_in(addr),
        .serial_enable_level_in(sen), .chain_head_in(head),
        .status_token_in(tok_in), .almost_empty_flag_bus_out(bus),
        .almost_empty_bus_oe_out(oe), .empty_bus_sync_out(sync),
        .status_token_out(tok_out));
    aesb_chain_model aesb_chain_model_i (.sys_clk_in(sys_clk), .rst_in(rst),
        .loop_en_in(loop_en), .gap_in(gap), .token_out_in(tok_out),
        .token_back_out(tok_in));
    // Results show while the bus is owned: every polled cycle, or the
    // cycle after an accepted strobe; the oldest note is the one due
    always @(posedge sys_clk) taken_d <= taken_q;
    initial forever begin
        @(posedge sys_clk);
        #5;
        if (oe === 1'h1 && (mode || taken_d)) begin
            if (exp_q.size() == 0) begin
                n_fail++;
                $display("unexpected at %0t got %h exp none", $time, bus);
            end else begin
                e_v = exp_q.pop_front();
                `AESB_CHECK({bus, sync, tok_out}, e_v)
            end
        end
    end
    // One run after a fresh reset; a polled run stops on a last word
    task automatic run(input logic pol, input int g, input int n);
        int e;
        int ph;
        int r;
        rst = 1'h1;
        mode = pol;
        head = pol;
        gap = g[1:0];
        repeat (5) @(posedge sys_clk); // Reset held five cycles
        #1;
        rst = 1'h0;
        for (e = 1; e <= n + 1; e++) begin
            r = $random(seed);
            flags = $random(seed);
            addr = r[1:0];
            sen = !pol && r[3:2] == 2'h0;
            strobe = !pol && e <= n && r[4];
            loop_en = e <= n;
            ph = (e - 2) % (4 + g);
            taken_q = !pol && strobe && !sen && e >= 2;
            if (taken_q) exp_q.push_back({flags[addr*8 +: 8], 2'h0});
            if (pol && e >= 2 && e <= n && ph < 4)
                exp_q.push_back({flags[ph*8 +: 8], ph == 0, ph == 3});
            @(posedge sys_clk);
            #1;
        end
        $display("run mode %0d gap %0d over, fails %0d", pol, g, n_fail);
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    initial begin
        run(1'h0, 0, 40);
        run(1'h1, 0, 13);
        run(1'h1, 2, 17);
        if (exp_q.size() != 0) begin
            n_fail++;
            $display("unexpected at %0t left %h exp 0", $time, exp_q.size());
        end
        final_report();
    end
endmodule // aesb_status_bus_tb_top
`default_nettype wire
